// ---- homing_pkg.sv ----
package homing_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned MS_NS         = 1000000;
  localparam int unsigned CYCLES_PER_MS = MS_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Register map (word index)
  // ----------------------------------------------------------------
  localparam logic [3:0] A_CTRL       = 4'h0;
  localparam logic [3:0] A_METHOD     = 4'h1;
  localparam logic [3:0] A_SW_SPEED   = 4'h2;
  localparam logic [3:0] A_ZERO_SPEED = 4'h3;
  localparam logic [3:0] A_TORQUE_LIM = 4'h4;
  localparam logic [3:0] A_DWELL_MS   = 4'h5;
  localparam logic [3:0] A_STATUS     = 4'h6;
  localparam logic [3:0] A_HOME_POS   = 4'h7;

  localparam int unsigned CTRL_START = 0;
  localparam int unsigned ST_BUSY    = 0;
  localparam int unsigned ST_DONE    = 1;
  localparam int unsigned ST_ERR     = 2;
  localparam int unsigned ST_STATE   = 4;

  localparam logic [7:0]  METHOD_RST = 8'h23;
  localparam logic [31:0] WORD_RST   = 32'h0;
  localparam logic [15:0] HALF_RST   = 16'h0;

  // ----------------------------------------------------------------
  // Method codes (two's complement)
  // ----------------------------------------------------------------
  localparam logic [7:0] M11  = 8'h0b;
  localparam logic [7:0] M12  = 8'h0c;
  localparam logic [7:0] M13  = 8'h0d;
  localparam logic [7:0] M14  = 8'h0e;
  localparam logic [7:0] M24  = 8'h18;
  localparam logic [7:0] M28  = 8'h1c;
  localparam logic [7:0] M33  = 8'h21;
  localparam logic [7:0] M34  = 8'h22;
  localparam logic [7:0] M35  = 8'h23;
  localparam logic [7:0] MN1  = 8'hff;
  localparam logic [7:0] MN2  = 8'hfe;
  localparam logic [7:0] MN3  = 8'hfd;
  localparam logic [7:0] MN4  = 8'hfc;
  localparam logic [7:0] MN5  = 8'hfb;
  localparam logic [7:0] MN6  = 8'hfa;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE     = 4'h0,
    S_SEARCH   = 4'h1,
    S_ZERO     = 4'h3,
    S_FINISH   = 4'h2,
    S_LIM_STOP = 4'h5,
    S_BACK     = 4'h7,
    S_FAIL     = 4'h8
  } state_t;

endpackage : homing_pkg

// ---- stop_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface stop_if;
  logic        arm;
  logic [15:0] torque;
  logic [15:0] limit;
  logic [15:0] dwell_ms;
  logic        hit;
  modport seq (output arm, output torque, output limit, output dwell_ms, input hit);
  modport det (input arm, input torque, input limit, input dwell_ms, output hit);
endinterface : stop_if
`default_nettype wire

// ---- stopper_detect.sv ----
`timescale 1ns/1ps
`default_nettype none
module stopper_detect
  import homing_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = CYCLES_PER_MS
) (
  input wire logic clk,
  input wire logic rst_n,
  stop_if.det      sif
);

  localparam int unsigned     PW       = $clog2(CYC_PER_MS + 1);
  localparam logic [PW-1:0]   PRE_LAST = PW'(CYC_PER_MS - 1);
  localparam logic [15:0]     MS_MAX   = 16'hffff;

  logic [PW-1:0] pre_ff;
  logic [15:0]   ms_ff;
  logic          fired_ff;
  logic          hit_ff;
  logic          contact;

  assign contact = sif.arm && (sif.torque >= sif.limit);

  // ----------------------------------------------------------------
  // Dwell timing while the torque stays at the limit.
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n || !contact) begin
      pre_ff <= '0;
    end else if (pre_ff == PRE_LAST) begin
      pre_ff <= '0;
    end else begin
      pre_ff <= pre_ff + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || !contact) begin
      ms_ff <= HALF_RST;
    end else if (pre_ff == PRE_LAST && ms_ff != MS_MAX) begin
      ms_ff <= ms_ff + 16'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || !contact) begin
      hit_ff   <= 1'b0;
      fired_ff <= 1'b0;
    end else begin
      hit_ff   <= !fired_ff && (ms_ff >= sif.dwell_ms);
      fired_ff <= fired_ff || (ms_ff >= sif.dwell_ms);
    end
  end

  assign sif.hit = hit_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_hit_needs_contact: assert property (sif.hit |-> $past(contact))
    else $error("Stopper hit without torque contact.");
  a_hit_after_dwell: assert property (sif.hit |-> $past(ms_ff) >= $past(sif.dwell_ms))
    else $error("Stopper hit before dwell time.");
  a_hit_one_pulse: assert property (sif.hit |=> !sif.hit)
    else $error("Stopper hit longer than one cycle.");

endmodule : stopper_detect
`default_nettype wire

// ---- homing_sequencer.sv ----
`timescale 1ns/1ps
`default_nettype none
module homing_sequencer
  import homing_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = CYCLES_PER_MS
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [31:0] reg_rdata_ff,
  input  wire logic        home_sw,
  input  wire logic        neg_limit,
  input  wire logic        pos_limit,
  input  wire logic        index_pulse,
  input  wire logic [15:0] torque,
  input  wire logic [31:0] enc_pos,
  input  wire logic        motor_stopped,
  output var  logic [31:0] speed_cmd_ff,
  output var  logic        dir_ccw_ff,
  output var  logic        drive_en_ff
);

  // ----------------------------------------------------------------
  // Method decoding
  // ----------------------------------------------------------------
  function automatic logic is_switch_index(input logic [7:0] m);
    return (m == M11) || (m == M12) || (m == M13) || (m == M14);
  endfunction : is_switch_index

  function automatic logic is_switch_edge(input logic [7:0] m);
    return (m == M24) || (m == M28);
  endfunction : is_switch_edge

  function automatic logic is_switch_only(input logic [7:0] m);
    return (m == MN5) || (m == MN6);
  endfunction : is_switch_only

  function automatic logic is_stopper(input logic [7:0] m);
    return (m == MN1) || (m == MN2) || (m == MN3) || (m == MN4);
  endfunction : is_stopper

  function automatic logic is_stopper_index(input logic [7:0] m);
    return (m == MN1) || (m == MN2);
  endfunction : is_stopper_index

  function automatic logic starts_ccw(input logic [7:0] m);
    return (m == M24) || (m == M34) || (m == MN2) || (m == MN4) || (m == MN6);
  endfunction : starts_ccw

  function automatic logic sw_inverted(input logic [7:0] m);
    return (m == M11) || (m == M13);
  endfunction : sw_inverted

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0]  method_ff;
  logic [31:0] sw_speed_ff;
  logic [31:0] zero_speed_ff;
  logic [15:0] torque_lim_ff;
  logic [15:0] dwell_ff;
  logic [31:0] home_pos_ff;
  logic        done_ff;
  logic        error_ff;
  logic        sw_prev_ff;
  state_t      state_ff;
  state_t      nxt_state;
  logic [31:0] nxt_speed;
  logic        nxt_dir;
  logic        capture;
  logic        set_done;
  logic        set_err;
  logic        start;
  logic        sw;
  logic        sw_rise;
  logic        sw_fall;
  logic        lim_hit;
  logic        stop_hit;
  logic [31:0] status;

  stop_if sif ();

  stopper_detect #(.CYC_PER_MS(CYC_PER_MS)) u_stop (
    .clk   (clk),
    .rst_n (rst_n),
    .sif   (sif)
  );

  assign sif.arm      = (state_ff == S_SEARCH) && is_stopper(method_ff);
  assign sif.torque   = torque;
  assign sif.limit    = torque_lim_ff;
  assign sif.dwell_ms = dwell_ff;
  assign stop_hit     = sif.hit;

  // ----------------------------------------------------------------
  // Input qualification
  // ----------------------------------------------------------------
  assign start   = reg_wr && (reg_addr == A_CTRL) && reg_wdata[CTRL_START]
                   && (state_ff == S_IDLE);
  assign sw      = home_sw ^ sw_inverted(method_ff);
  assign sw_rise = sw && !sw_prev_ff;
  assign sw_fall = !sw && sw_prev_ff;
  assign lim_hit = dir_ccw_ff ? pos_limit : neg_limit;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sw_prev_ff <= 1'b0;
    end else begin
      sw_prev_ff <= sw;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_speed = speed_cmd_ff;
    nxt_dir   = dir_ccw_ff;
    capture   = 1'b0;
    set_done  = 1'b0;
    set_err   = 1'b0;
    unique case (state_ff)
      S_IDLE: begin
        nxt_speed = WORD_RST;
        if (start) begin
          nxt_dir = starts_ccw(method_ff);
          if (method_ff == M35) begin
            capture  = 1'b1;
            set_done = 1'b1;
          end else if (method_ff == M33 || method_ff == M34) begin
            nxt_state = S_ZERO;
            nxt_speed = zero_speed_ff;
          end else if (is_switch_index(method_ff) || is_switch_edge(method_ff)
                       || is_switch_only(method_ff) || is_stopper(method_ff)) begin
            nxt_state = S_SEARCH;
            nxt_speed = sw_speed_ff;
          end else begin
            set_err = 1'b1;
          end
        end
      end
      S_SEARCH: begin
        if (is_stopper(method_ff)) begin
          if (stop_hit && is_stopper_index(method_ff)) begin
            nxt_state = S_ZERO;
            nxt_dir   = !dir_ccw_ff;
            nxt_speed = zero_speed_ff;
          end else if (stop_hit) begin
            capture   = 1'b1;
            nxt_state = S_FINISH;
            nxt_speed = WORD_RST;
          end
        end else if (lim_hit && is_switch_only(method_ff)) begin
          nxt_state = S_FAIL;
          nxt_speed = WORD_RST;
          set_err   = 1'b1;
        end else if (lim_hit) begin
          nxt_state = S_LIM_STOP;
          nxt_speed = WORD_RST;
        end else if (sw_fall && is_switch_index(method_ff)) begin
          nxt_state = S_ZERO;
          nxt_speed = zero_speed_ff;
        end else if (sw_rise && !is_switch_index(method_ff)) begin
          capture   = 1'b1;
          nxt_state = S_FINISH;
          nxt_speed = WORD_RST;
        end
      end
      S_LIM_STOP: begin
        nxt_speed = WORD_RST;
        if (motor_stopped) begin
          nxt_state = S_BACK;
          nxt_dir   = !dir_ccw_ff;
          nxt_speed = sw_speed_ff;
        end
      end
      S_BACK: begin
        if (lim_hit) begin
          nxt_state = S_FAIL;
          nxt_speed = WORD_RST;
          set_err   = 1'b1;
        end else if (sw_rise && is_switch_index(method_ff)) begin
          nxt_state = S_ZERO;
          nxt_dir   = !dir_ccw_ff;
          nxt_speed = zero_speed_ff;
        end else if (sw_rise) begin
          capture   = 1'b1;
          nxt_state = S_FINISH;
          nxt_speed = WORD_RST;
        end
      end
      S_ZERO: begin
        if (lim_hit) begin
          nxt_state = S_FAIL;
          nxt_speed = WORD_RST;
          set_err   = 1'b1;
        end else if (index_pulse) begin
          capture   = 1'b1;
          nxt_state = S_FINISH;
          nxt_speed = WORD_RST;
        end
      end
      S_FINISH: begin
        nxt_speed = WORD_RST;
        if (motor_stopped) begin
          nxt_state = S_IDLE;
          set_done  = 1'b1;
        end
      end
      S_FAIL: begin
        nxt_speed = WORD_RST;
        if (motor_stopped) begin
          nxt_state = S_IDLE;
        end
      end
      default: begin
        nxt_state = S_IDLE;
        nxt_speed = WORD_RST;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff     <= S_IDLE;
      speed_cmd_ff <= WORD_RST;
      dir_ccw_ff   <= 1'b0;
      drive_en_ff  <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      speed_cmd_ff <= nxt_speed;
      dir_ccw_ff   <= nxt_dir;
      drive_en_ff  <= (nxt_state != S_IDLE);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      home_pos_ff <= WORD_RST;
    end else if (capture) begin
      home_pos_ff <= enc_pos;
    end
  end

  // ----------------------------------------------------------------
  // Completion flags: a set wins over the clear from a new start.
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      done_ff  <= 1'b0;
      error_ff <= 1'b0;
    end else begin
      done_ff  <= set_done || (done_ff && !start);
      error_ff <= set_err || (error_ff && !start);
    end
  end

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      method_ff     <= METHOD_RST;
      sw_speed_ff   <= WORD_RST;
      zero_speed_ff <= WORD_RST;
      torque_lim_ff <= HALF_RST;
      dwell_ff      <= HALF_RST;
    end else if (reg_wr) begin
      unique case (reg_addr)
        A_METHOD:     method_ff     <= reg_wdata[7:0];
        A_SW_SPEED:   sw_speed_ff   <= reg_wdata;
        A_ZERO_SPEED: zero_speed_ff <= reg_wdata;
        A_TORQUE_LIM: torque_lim_ff <= reg_wdata[15:0];
        A_DWELL_MS:   dwell_ff      <= reg_wdata[15:0];
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    status = WORD_RST;
    status[ST_BUSY] = (state_ff != S_IDLE);
    status[ST_DONE] = done_ff;
    status[ST_ERR]  = error_ff;
    status[ST_STATE +: 4] = state_ff;
  end

  always_ff @(posedge clk) begin
    if (!rst_n || !reg_rd) begin
      reg_rdata_ff <= WORD_RST;
    end else begin
      unique case (reg_addr)
        A_METHOD:     reg_rdata_ff <= {24'h0, method_ff};
        A_SW_SPEED:   reg_rdata_ff <= sw_speed_ff;
        A_ZERO_SPEED: reg_rdata_ff <= zero_speed_ff;
        A_TORQUE_LIM: reg_rdata_ff <= {16'h0, torque_lim_ff};
        A_DWELL_MS:   reg_rdata_ff <= {16'h0, dwell_ff};
        A_STATUS:     reg_rdata_ff <= status;
        A_HOME_POS:   reg_rdata_ff <= home_pos_ff;
        default:      reg_rdata_ff <= WORD_RST;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence seq_limit_met;
    state_ff == S_SEARCH && lim_hit && is_switch_index(method_ff);
  endsequence

  sequence seq_limit_stopped;
    state_ff == S_LIM_STOP && motor_stopped;
  endsequence

  a_idle_holds: assert property (state_ff == S_IDLE && !start |=> state_ff == S_IDLE)
    else $error("Homing left idle without a start.");
  a_here_home: assert property (start && method_ff == M35
      |=> state_ff == S_IDLE && done_ff && home_pos_ff == $past(enc_pos))
    else $error("Method 35 did not home in place.");
  a_limit_reverse: assert property (seq_limit_met ##1 seq_limit_stopped
      |=> state_ff == S_BACK && dir_ccw_ff != $past(dir_ccw_ff, 2)
          && speed_cmd_ff == sw_speed_ff)
    else $error("No reversal after limit stop.");
  a_limit_stop: assert property (seq_limit_met |=> speed_cmd_ff == WORD_RST)
    else $error("Limit did not stop the search.");
  a_fall_zero: assert property (state_ff == S_SEARCH && is_switch_index(method_ff)
      && !lim_hit && sw_fall |=> state_ff == S_ZERO && speed_cmd_ff == zero_speed_ff)
    else $error("Switch release did not select zero speed.");
  a_back_turn: assert property (state_ff == S_BACK && is_switch_index(method_ff)
      && !lim_hit && sw_rise |=> state_ff == S_ZERO && !dir_ccw_ff)
    else $error("Switch after reversal did not turn negative.");
  a_index_home: assert property (state_ff == S_ZERO && !lim_hit && index_pulse
      |=> state_ff == S_FINISH && home_pos_ff == $past(enc_pos))
    else $error("Index pulse position not captured.");
  a_edge_home: assert property (state_ff == S_SEARCH && is_switch_edge(method_ff)
      && !lim_hit && sw_rise |=> home_pos_ff == $past(enc_pos))
    else $error("Switch edge position not captured.");
  a_m56_error: assert property (state_ff == S_SEARCH && is_switch_only(method_ff)
      && lim_hit |=> error_ff && speed_cmd_ff == WORD_RST)
    else $error("Limit in methods -5/-6 raised no error.");
  a_stopper_turn: assert property (state_ff == S_SEARCH && is_stopper_index(method_ff)
      && stop_hit |=> state_ff == S_ZERO && dir_ccw_ff != $past(dir_ccw_ff))
    else $error("Stopper did not reverse the drive.");
  a_finish_done: assert property (state_ff == S_FINISH && motor_stopped
      |=> state_ff == S_IDLE && done_ff)
    else $error("Finish did not report completion.");
  a_start_dir: assert property (start && method_ff == M28 |=> !dir_ccw_ff)
    else $error("Method 28 did not start clockwise.");

endmodule : homing_sequencer
`default_nettype wire

// ---- motor_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Motor with encoder, home switch, limits and end stoppers.
// ----------------------------------------------------------------
module motor_model (
  input  wire logic               clk,
  input  wire logic               load,
  input  wire logic signed [31:0] load_pos,
  input  wire logic signed [31:0] sw_lo,
  input  wire logic signed [31:0] sw_hi,
  input  wire logic               sw_inv,
  input  wire logic               wall_en,
  input  wire logic        [31:0] speed_cmd,
  input  wire logic               dir_ccw,
  output var  logic        [31:0] enc_pos,
  output var  logic               home_sw,
  output var  logic               neg_limit,
  output var  logic               pos_limit,
  output var  logic               index_pulse,
  output var  logic        [15:0] torque,
  output var  logic               motor_stopped
);
  logic signed [31:0] pos_ff;
  logic signed [31:0] nxt_pos;
  logic signed [31:0] vel;
  // Speed applies with no ramp; stoppers at 800 counts block motion.
  always_comb begin
    vel = signed'(speed_cmd);
    nxt_pos = dir_ccw ? pos_ff + vel : pos_ff - vel;
    if (wall_en && nxt_pos > 800)
      nxt_pos = 800;
    if (wall_en && nxt_pos < -800)
      nxt_pos = -800;
  end
  always @(posedge clk) begin
    pos_ff <= load ? load_pos : nxt_pos;
  end
  assign enc_pos       = pos_ff;
  assign home_sw       = ((pos_ff >= sw_lo) && (pos_ff <= sw_hi)) ^ sw_inv;
  assign neg_limit     = pos_ff <= -1000;
  assign pos_limit     = pos_ff >= 1000;
  assign index_pulse   = (pos_ff[5:0] == 6'h00) && (vel != 0);
  assign torque        = (wall_en && (pos_ff == 800 || pos_ff == -800)) ? 16'h0100 : 16'h0010;
  assign motor_stopped = vel == 0;
endmodule : motor_model
`default_nettype wire

// ---- homing_sequencer_test.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Self-checking bench: one homing run per table entry.
// ----------------------------------------------------------------
module homing_sequencer_test import homing_pkg::*;;
  typedef struct {
    logic [7:0] m;
    int start; int lo; int hi;
    logic inv; logic wall; logic err;
    int home;
  } case_t;
  logic clk, rst_n, reg_wr, reg_rd, home_sw, neg_limit, pos_limit;
  logic index_pulse, motor_stopped, dir_ccw_ff, drive_en_ff, load, sw_inv, wall_en;
  logic [3:0]  reg_addr;
  logic [15:0] torque;
  logic [31:0] reg_wdata, reg_rdata_ff, enc_pos, speed_cmd_ff, d;
  logic signed [31:0] load_pos, sw_lo, sw_hi;
  int mismatches, cmp_count, cyc, seed, k;
  case_t c;
  case_t cases[20] = '{
    '{M14, 200, 100, 150, 0, 0, 0, 64},
    '{M14, 120, 100, 150, 0, 0, 0, 64},
    '{M14, 50, 100, 150, 0, 0, 0, 64},
    '{M11, 200, 100, 150, 1, 0, 0, 64},
    '{M12, 200, 100, 150, 0, 0, 0, 64},
    '{M13, 200, 100, 150, 1, 0, 0, 64},
    '{M24, 0, 100, 150, 0, 0, 0, 100},
    '{M28, 200, 100, 150, 0, 0, 0, 150},
    '{M28, 50, 100, 150, 0, 0, 0, 100},
    '{M33, 200, 5000, 5000, 0, 0, 0, 192},
    '{M34, 200, 5000, 5000, 0, 0, 0, 256},
    '{M35, 300, 5000, 5000, 0, 0, 0, 300},
    '{MN1, 0, 5000, 5000, 0, 1, 0, -768},
    '{MN2, 0, 5000, 5000, 0, 1, 0, 768},
    '{MN3, 0, 5000, 5000, 0, 1, 0, -800},
    '{MN4, 0, 5000, 5000, 0, 1, 0, 800},
    '{MN5, 200, 100, 150, 0, 0, 0, 150},
    '{MN6, 0, 100, 150, 0, 0, 0, 100},
    '{MN5, 50, 2000, 2100, 0, 0, 1, 0},
    '{8'h05, 0, 5000, 5000, 0, 0, 1, 0}};
  homing_sequencer #(.CYC_PER_MS(4)) uut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .home_sw(home_sw), .neg_limit(neg_limit), .pos_limit(pos_limit),
    .index_pulse(index_pulse), .torque(torque), .enc_pos(enc_pos),
    .motor_stopped(motor_stopped), .speed_cmd_ff(speed_cmd_ff), .dir_ccw_ff(dir_ccw_ff),
    .drive_en_ff(drive_en_ff));
  motor_model motor (.clk(clk), .load(load), .load_pos(load_pos), .sw_lo(sw_lo),
    .sw_hi(sw_hi), .sw_inv(sw_inv), .wall_en(wall_en), .speed_cmd(speed_cmd_ff),
    .dir_ccw(dir_ccw_ff), .enc_pos(enc_pos), .home_sw(home_sw), .neg_limit(neg_limit),
    .pos_limit(pos_limit), .index_pulse(index_pulse), .torque(torque),
    .motor_stopped(motor_stopped));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  function automatic logic exp_dir(input logic [7:0] m);
    return (m == M24) || (m == M34) || (m == MN2) || (m == MN4) || (m == MN6);
  endfunction : exp_dir
  function automatic logic [31:0] exp_speed(input logic [7:0] m);
    return (m == M33 || m == M34) ? 32'h1 : 32'h2;
  endfunction : exp_speed
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    v = reg_rdata_ff;
  endtask : rd
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      mismatches++;
      end_sim();
    end
  end
  initial begin
    seed = 18597;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {load, load_pos, sw_lo, sw_hi, sw_inv, wall_en} = {1'b1, 32'sd0, 32'sd5000, 32'sd5000, 2'b00};
    rst_n = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(A_METHOD, d);
    check("method_reset", d, {24'h0, METHOD_RST});
    rd(A_STATUS, d);
    check("status_reset", d, 32'h0);
    wr(4'h8 + 4'($random(seed) & 7), $random(seed));
    rd(4'h8 + 4'($random(seed) & 7), d);
    check("unmapped_read", d, 32'h0);
    wr(A_SW_SPEED, 32'h2);
    wr(A_ZERO_SPEED, 32'h1);
    wr(A_TORQUE_LIM, 32'h80);
    wr(A_DWELL_MS, 32'h1 + ($random(seed) & 3));
    $display("register test done");
    foreach (cases[i]) begin
      c = cases[i];
      {load_pos, sw_lo, sw_hi, sw_inv, wall_en} <= {c.start, c.lo, c.hi, c.inv, c.wall};
      load <= 1'b1;
      @(posedge clk);
      load <= 1'b0;
      wr(A_METHOD, {24'h0, c.m});
      wr(A_CTRL, 32'h1);
      if (c.m != M35 && c.m != 8'h05) begin
        check("direction", {31'h0, dir_ccw_ff}, {31'h0, exp_dir(c.m)});
        check("start_speed", speed_cmd_ff, exp_speed(c.m));
        check("drive_enable", {31'h0, drive_en_ff}, 32'h1);
      end
      k = 0;
      d = 32'h1;
      while (d[ST_BUSY] !== 1'b0 && k < 5000) begin
        rd(A_STATUS, d);
        k++;
      end
      check("status_flags", {29'h0, d[2:0]}, {29'h0, c.err, !c.err, 1'b0});
      check("drive_idle", {31'h0, drive_en_ff}, 32'h0);
      check("speed_idle", speed_cmd_ff, 32'h0);
      rd(A_HOME_POS, d);
      if (!c.err)
        check("home_position", d, c.home);
      $display("test %0d method %h done", i, c.m);
    end
    end_sim();
  end
endmodule : homing_sequencer_test
`default_nettype wire
